// *** dv/rtcm_checker.sv ***
// Bus-level checker bound to the clock/calendar core.
module rtcm_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       prev_scl;
  logic       prev_sda;
  logic       in_frame;
  logic       past_addr;
  logic [3:0] bit_cnt;
  logic [7:0] addr_byte;
  logic       rise;
  logic       start_c;
  logic       stop_c;
  logic       addr_done;
  logic       match;

  // Bus events decoded from the same samples the core takes.
  assign rise      = scl & ~prev_scl;
  assign start_c   = scl & prev_scl & prev_sda & ~sda_in;
  assign stop_c    = scl & prev_scl & ~prev_sda & sda_in;
  assign addr_done = past_addr | (bit_cnt == 4'h8);
  assign match     = (addr_byte[7:1] == 7'h6F);

  // Line history; released lines idle high.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_scl <= 1'b1;
      prev_sda <= 1'b1;
    end
    else
    begin
      prev_scl <= scl;
      prev_sda <= sda_in;
    end
  end

  // Bit position in the byte; a repeated start restarts the address phase.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_frame  <= 1'b0;
      past_addr <= 1'b0;
      bit_cnt   <= 4'h0;
    end
    else if (start_c)
    begin
      in_frame  <= 1'b1;
      past_addr <= 1'b0;
      bit_cnt   <= 4'h0;
    end
    else if (stop_c)
      in_frame <= 1'b0;
    else if (rise)
    begin
      bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
      if (bit_cnt == 4'h8)
        past_addr <= 1'b1;
    end
  end

  // Address byte shifted in most significant bit first.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      addr_byte <= 8'h00;
    else if (rise && !past_addr && bit_cnt < 4'h8)
      addr_byte <= {addr_byte[6:0], sda_in};
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chk_foreign_quiet:
    assert property (in_frame && addr_done && !match |-> !sda_oe)
    else $error("bus driven after a foreign address");
  chk_addr_ack:
    assert property (rise && in_frame && !past_addr && bit_cnt == 4'h8 && match |-> sda_oe)
    else $error("own address not acknowledged");
  chk_write_ack:
    assert property (rise && in_frame && past_addr && bit_cnt == 4'h8 && match && !addr_byte[0]
      |-> sda_oe)
    else $error("written byte not acknowledged");
  chk_read_release:
    assert property (rise && in_frame && past_addr && bit_cnt == 4'h8 && addr_byte[0]
      |-> !sda_oe)
    else $error("host acknowledge slot driven");
  chk_addr_quiet:
    assert property (in_frame && !addr_done |-> !sda_oe)
    else $error("bus driven during address byte");
  chk_steady_high:
    assert property (scl && $past(scl) |-> $stable(sda_oe))
    else $error("data changed while clock high");
  chk_reset_quiet:
    assert property ($rose(rst_n) |-> !sda_oe ##1 !sda_oe)
    else $error("bus driven right after reset");
  chk_idle_quiet:
    assert property (!in_frame |-> !sda_oe)
    else $error("bus driven outside a transfer");

  cov_foreign: cover property (in_frame && addr_done && !match && stop_c);
  cov_wr_ack: cover property (rise && past_addr && bit_cnt == 4'h8 && !addr_byte[0] && sda_oe);
  cov_rd_data: cover property (rise && past_addr && addr_byte[0] && bit_cnt < 4'h8 && sda_oe);
endmodule

bind rtcm_core rtcm_checker u_chk (
  .core_clk(core_clk),
  .rst_n   (rst_n),
  .scl     (scl),
  .sda_in  (sda_in),
  .sda_oe  (sda_oe)
);

// *** dv/rtcm_core_tb.sv ***
// Self-checking bench: register map, write lock and calendar carries of the core.
module rtcm_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK_C = 2000;
  logic        core_clk;
  logic        rst_n;
  wire logic   scl;
  wire logic   sda_in;
  logic        sda_out;
  logic        sda_oe;
  logic        ack;
  logic [31:0] seed = 32'h6386;
  int          errors = 0;
  int          tests_run = 0;
  int          cycles = 0;
  logic [7:0]  mem_exp [20];
  logic [7:0]  rdq [$];
  // Time section images, seconds low: two ticks before and after a carry.
  logic [55:0] tin [6] = '{56'h06_04_02_28_31_59_58, 56'h03_05_02_28_A3_59_58,
    56'h02_00_02_28_A3_59_58, 56'h05_99_12_31_A3_59_58, 56'h01_00_02_28_11_59_58,
    56'h06_10_04_30_A3_59_58};
  logic [55:0] tout [6] = '{56'h00_04_02_29_12_00_00, 56'h04_05_03_01_80_00_00,
    56'h03_00_02_29_80_00_00, 56'h06_00_01_01_80_00_00, 56'h01_00_02_28_32_00_00,
    56'h00_10_05_01_80_00_00};

  rtcm_core #(.TICK_CYCLES(TICK_C)) u_dut (.core_clk(core_clk), .rst_n(rst_n), .scl(scl),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));
  rtcm_host u_host (.core_clk(core_clk), .sda_out(sda_out), .sda_oe(sda_oe), .scl(scl),
    .sda_in(sda_in));

  // Clock at 25 MHz.
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // A hang is cut short well above the expected run length.
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 95000)
    begin
      errors++;
      end_sim();
    end
  end

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  // Bits that are kept in the alarm section; the others read back as zero.
  function automatic logic [7:0] loc_mask(input logic [4:0] a);
    return (a[4:1] == 4'h7) ? 8'hBF : (a == 5'h10) ? 8'h9F : (a == 5'h11) ? 8'h87 : 8'hFF;
  endfunction

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_ack(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: ack %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d [$]);
    u_host.start();
    u_host.put(8'hDE, ack);
    chk_ack(ack, 1'b1);
    u_host.put(ptr, ack);
    foreach (d[i])
      u_host.put(d[i], ack);
    u_host.stop();
  endtask

  // Random read from ptr, or a current-address read when cur is set.
  task automatic rd(input logic [7:0] ptr, input int n, input logic cur);
    logic [7:0] b;
    rdq = {};
    u_host.start();
    if (!cur)
    begin
      u_host.put(8'hDE, ack);
      u_host.put(ptr, ack);
      u_host.start();
    end
    u_host.put(8'hDF, ack);
    chk_ack(ack, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      u_host.get(i < n - 1, b);
      rdq.push_back(b);
    end
    u_host.stop();
  endtask

  task automatic rd_chk(input logic [4:0] a, input int n);
    rd({3'h0, a}, n, 1'b0);
    foreach (rdq[i])
      chk8(rdq[i], mem_exp[a + i]);
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Main sequence: reset image, refusals, section limits, then calendar carries.
  initial
  begin
    logic [7:0] d [$];
    logic [7:0] b;
    logic [4:0] a;
    int         n;
    rst_n = 1'b0;
    foreach (mem_exp[i])
      mem_exp[i] = 8'h00;
    mem_exp[7] = 8'h01;
    repeat (8) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (2 * TICK_C) @(negedge core_clk);
    rd_chk(5'h00, 7);
    rd_chk(5'h07, 5);
    rd_chk(5'h0C, 6);
    rd_chk(5'h12, 2);
    repeat (3)
    begin
      b = rnd();
      if (b[7:1] == 7'h6F)
        b = 8'h00;
      u_host.start();
      u_host.put(b, ack);
      chk_ack(ack, 1'b0);
      u_host.stop();
    end
    d = {8'h12, 8'h34, 8'h12, 8'h15, 8'h06, 8'h21, 8'h03};
    wr(8'h00, d);
    rd_chk(5'h00, 7);
    d = {8'h10};
    wr(8'h07, d);
    mem_exp[7] = 8'h11;
    d = {8'hFF};
    wr(8'h09, d);
    rd_chk(5'h07, 3);
    // Page writes from any start in 0Ch to 13h; bytes past the section end are dropped.
    for (int k = 0; k < 8; k++)
    begin
      a = (k < 2) ? 5'h11 + 5'(2 * k) : 5'h0C + 5'(rnd() % 8);
      n = (k < 2) ? 3 : 1 + rnd() % 3;
      d = {};
      repeat (n) d.push_back(rnd());
      wr({3'h0, a}, d);
      foreach (d[i])
        if (a + i <= ((a < 5'h12) ? 5'h11 : 5'h13))
          mem_exp[a + i] = d[i] & loc_mask(5'(a + i));
      rd_chk(5'h0C, 6);
      rd_chk(5'h12, 2);
    end
    // The read is latched between the second and third tick after the stop.
    foreach (tin[c])
    begin
      repeat (TICK_C / 2) @(negedge core_clk);
      d = {};
      for (int i = 0; i < 7; i++)
        d.push_back(tin[c][8*i +: 8]);
      wr(8'h00, d);
      repeat (TICK_C * 11 / 4 - 220) @(negedge core_clk);
      rd(8'h00, 7, 1'b0);
      foreach (rdq[i])
        chk8(rdq[i], tout[c][8*i +: 8]);
    end
    rd(8'h00, 1, 1'b1);
    chk8(rdq[0], 8'h10);
    end_sim();
  end
endmodule

// *** dv/rtcm_host.sv ***
// Two-wire bus host model that frames transfers towards the clock/calendar core.
module rtcm_host (
  input  wire logic core_clk,
  input  wire logic sda_out,
  input  wire logic sda_oe,
  output logic      scl,
  output wire logic sda_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic host_low;

  // Open-drain line with a pull-up: low while either side pulls it.
  assign sda_in = ~host_low & (sda_oe ? sda_out : 1'b1);

  // The bus idles released with the clock high.
  initial
  begin
    scl      = 1'b1;
    host_low = 1'b0;
  end

  // One bus clock: data set while the clock is low, sampled mid-high.
  task automatic bit_io(input logic b, output logic got);
    host_low = ~b;
    repeat (2) @(negedge core_clk);
    scl = 1'b1;
    repeat (2) @(negedge core_clk);
    got = sda_in;
    repeat (2) @(negedge core_clk);
    scl = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask

  // Start and repeated start: data falls while the clock is high.
  task automatic start();
    host_low = 1'b0;
    repeat (2) @(negedge core_clk);
    scl = 1'b1;
    repeat (2) @(negedge core_clk);
    host_low = 1'b1;
    repeat (2) @(negedge core_clk);
    scl = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask

  // Stop frees the bus; every read is closed this way.
  task automatic stop();
    host_low = 1'b1;
    repeat (2) @(negedge core_clk);
    scl = 1'b1;
    repeat (2) @(negedge core_clk);
    host_low = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask

  // Byte out, then the line is released for the device's acknowledge.
  task automatic put(input logic [7:0] b, output logic ack);
    logic got;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], got);
    bit_io(1'b1, got);
    ack = ~got;
  endtask

  // Byte in; the host acknowledges all but the last byte.
  task automatic get(input logic more, output logic [7:0] b);
    logic got;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, got);
      b[i] = got;
    end
    bit_io(~more, got);
  endtask
endmodule

// *** rtl/rtcm_core.sv ***
// Two-wire register map and BCD time-of-day calendar core.
//
// Behaviour
// (RULE1) Answer only slave byte 1101111x; reach locations 00h to 13h.
// (RULE2) Location 09h unused: writes ignored, reads return zero.
// (RULE3) Accept single-byte and page writes starting at any location.
// (RULE4) Four sections: time, control/status, alarm, scratch; nothing above 13h.
// (RULE5) Time writes ignored unless the unlock bit, status bit 4, is set.
// (RULE6) A multi-byte transfer stays inside the section it started in; here only writes do, sequential reads cross sections.
// (RULE7) Transfers may start at any location inside a section.
// (RULE8) Random reads return current contents; sequential reads continue onward.
// (RULE9) Read start latches time counters into a holding buffer.
// (RULE10) After a read the pointer holds last location plus one.
// (RULE11) Control, alarm and scratch writes ignore the unlock bit.
// (RULE12) Reset: all locations zero, status reads 01h.
// (RULE13) Time registers are packed BCD within their documented ranges.
// (RULE14) Weekday counts 0 to 6, wraps to 0, defaults to 0.
// (RULE15) Hours bit 7 selects 24-hour; otherwise bit 5 marks afternoon.
// (RULE16) Default is 12-hour format with afternoon bit clear.
// (RULE17) Every year divisible by 4, 00 included, is a leap year.
// (RULE18) Date rolls to 1 at the true end of each month.
// (RULE19) Counters stay frozen after power loss until a time write.
// (RULE20) Stop after a valid time write starts counting, tick resynchronised.
// (RULE21) Each tick increments seconds with BCD carries through all fields.
// (RULE22) 12-hour counts 12,1..11; afternoon toggles passing 11 to 12.
// (RULE23) Unused high bits of time, alarm and trim registers read zero.
`include "rtcm_regs.svh"

module rtcm_core
  import rtcm_pkg::*;
#(
  parameter int TICK_CYCLES = `RTCM_TICK_PERIOD_NS / `RTCM_CLK_PERIOD_NS
)(
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic scl,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe
);

  localparam int TW = $clog2(TICK_CYCLES);

  // A one-second divider needs at least two cycles to be meaningful.
  if (TICK_CYCLES < 2)
  begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end

  logic [7:0]  mem [0:`RTCM_NUM_LOC-1];
  logic [7:0]  shadow [0:6];
  logic        scl_q;
  logic        sda_q;
  rtcm_state_t state;
  logic [2:0]  cnt;
  logic [7:0]  shift;
  logic        ack_drv;
  logic        rw;
  logic [4:0]  ptr;
  rtcm_sect_t  xfer_sect;
  logic        sr_arst;
  logic        sr_xtoscb;
  logic        sr_clock_write_unlock;
  logic        sr_alm;
  logic        sr_bat;
  logic        sr_total_power_loss_flag;
  logic        sr_read;
  logic        time_wr_pend;
  logic        running;
  logic [TW-1:0] tick_cnt;
  logic        tick;
  logic        start_c;
  logic        stop_c;
  logic        rise;
  logic        fall;
  logic [7:0]  in_byte;
  logic        byte_done;
  logic        wr_en;
  logic        time_wr;
  logic        rd_load;
  logic        rd_start;
  logic [7:0]  nx_sec;
  logic [7:0]  nx_min;
  logic [7:0]  nx_hour;
  logic [7:0]  nx_date;
  logic [7:0]  nx_month;
  logic [7:0]  nx_year;
  logic [7:0]  nx_wday;
  logic [7:0]  rd_byte;

  // Section number of a location; used by pointer load and write gating.
  function automatic rtcm_sect_t sect_of(input logic [4:0] a);
    if (a <= `RTCM_ADDR_WDAY)
      sect_of = 2'd0;
    else if (a <= `RTCM_ADDR_DTRIM)
      sect_of = 2'd1;
    else if (a <= `RTCM_ADDR_ALM_WDAY)
      sect_of = 2'd2;
    else
      sect_of = 2'd3;
  endfunction

  // Bits that exist at each location; the rest store and read as zero.
  function automatic logic [7:0] wmask(input logic [4:0] a);
    case (a)
      `RTCM_ADDR_SEC, `RTCM_ADDR_MIN: wmask = `RTCM_MASK_SEC; // RULE23
      `RTCM_ADDR_HOUR:                wmask = `RTCM_MASK_HOUR;
      `RTCM_ADDR_DATE:                wmask = `RTCM_MASK_DATE;
      `RTCM_ADDR_MONTH:               wmask = `RTCM_MASK_MONTH;
      `RTCM_ADDR_WDAY:                wmask = `RTCM_MASK_WDAY;
      `RTCM_ADDR_DTRIM:               wmask = `RTCM_MASK_DTRIM;
      `RTCM_ADDR_ALM_HOUR,
      `RTCM_ADDR_ALM_DATE:            wmask = `RTCM_MASK_ALM_HOUR;
      `RTCM_ADDR_ALM_MONTH:           wmask = `RTCM_MASK_ALM_MONTH;
      `RTCM_ADDR_ALM_WDAY:            wmask = `RTCM_MASK_ALM_WDAY;
      `RTCM_ADDR_STATUS,
      `RTCM_ADDR_UNUSED:              wmask = `RTCM_RESET_VALUE; // RULE2
      default:                        wmask = (a > `RTCM_ADDR_LAST) ? `RTCM_RESET_VALUE
                                                                   : `RTCM_MASK_ALL;
    endcase
  endfunction

  // BCD increment of a two-digit value.
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9)
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    else
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
  endfunction

  // Bus edges; pins are already synchronous to core_clk.
  assign start_c = scl && scl_q && sda_q && !sda_in;
  assign stop_c  = scl && scl_q && !sda_q && sda_in;
  assign rise    = scl && !scl_q;
  assign fall    = !scl && scl_q;
  assign in_byte = {shift[6:0], sda_in};
  assign byte_done = rise && (cnt == 3'd7);
  assign sda_out = 1'b0;
  assign rd_byte = rd_val(ptr);

  // Remember the previous pin levels for edge detection.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda_in;
    end
  end

  // Write strobes and read load points of the serial state machine.
  always_comb
  begin
    wr_en    = (state == RTCM_WR) && byte_done
               && (sect_of(ptr) == xfer_sect) && (ptr <= `RTCM_ADDR_LAST); // RULE6
    time_wr  = wr_en && (ptr <= `RTCM_ADDR_WDAY) && sr_clock_write_unlock; // RULE5
    rd_start = (state == RTCM_ADDR) && byte_done
               && (shift[6:0] == `RTCM_SLAVE_ADDR) && sda_in;
    rd_load  = fall && ack_drv && ((state == RTCM_ADDR_ACK && rw)
                                   || state == RTCM_RD_ACK);
  end

  // Serial protocol: address match, pointer load, byte shift and acknowledge.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state     <= RTCM_IDLE;
      cnt       <= 3'd0;
      shift     <= `RTCM_RESET_VALUE;
      ack_drv   <= 1'b0;
      rw        <= 1'b0;
      ptr       <= `RTCM_ADDR_SEC;
      xfer_sect <= 2'd0;
      sda_oe    <= 1'b0;
    end
    else if (start_c)
    begin
      state   <= RTCM_ADDR;
      cnt     <= 3'd0;
      ack_drv <= 1'b0;
      sda_oe  <= 1'b0;
    end
    else if (stop_c)
    begin
      state  <= RTCM_IDLE;
      sda_oe <= 1'b0;
    end
    else
    begin
      case (state)
        RTCM_ADDR, RTCM_PTR, RTCM_WR:
        begin
          if (rise)
          begin
            shift <= in_byte;
            cnt   <= cnt + 3'd1;
          end
          if (byte_done)
          begin
            cnt <= 3'd0;
            if (state == RTCM_ADDR)
            begin
              // Other slave addresses are left alone until the next start.
              if (shift[6:0] == `RTCM_SLAVE_ADDR) // RULE1
              begin
                state     <= RTCM_ADDR_ACK;
                rw        <= sda_in;
                xfer_sect <= sect_of(ptr); // RULE7
              end
              else
                state <= RTCM_IDLE;
            end
            else if (state == RTCM_PTR)
            begin
              ptr       <= in_byte[4:0]; // RULE7
              xfer_sect <= sect_of(in_byte[4:0]);
              state     <= RTCM_PTR_ACK;
            end
            else
            begin
              ptr   <= (ptr == `RTCM_ADDR_LAST) ? `RTCM_ADDR_SEC : ptr + 5'd1; // RULE3
              state <= RTCM_WR_ACK;
            end
          end
        end
        RTCM_ADDR_ACK, RTCM_PTR_ACK, RTCM_WR_ACK:
        begin
          if (fall && !ack_drv)
          begin
            ack_drv <= 1'b1;
            sda_oe  <= 1'b1;
          end
          else if (fall)
          begin
            ack_drv <= 1'b0;
            if (rd_load)
            begin
              shift  <= rd_byte;
              sda_oe <= !rd_byte[7];
              state  <= RTCM_RD;
            end
            else
            begin
              sda_oe <= 1'b0;
              state  <= (state == RTCM_ADDR_ACK) ? RTCM_PTR : RTCM_WR;
            end
          end
        end
        RTCM_RD:
        begin
          if (fall)
          begin
            shift  <= {shift[6:0], 1'b0};
            sda_oe <= !shift[6];
          end
          if (rise)
          begin
            cnt <= cnt + 3'd1;
            if (cnt == 3'd7)
            begin
              state <= RTCM_RD_ACK;
              ptr   <= (ptr == `RTCM_ADDR_LAST) ? `RTCM_ADDR_SEC : ptr + 5'd1; // RULE10
            end
          end
        end
        RTCM_RD_ACK:
        begin
          if (fall && !ack_drv)
            sda_oe <= 1'b0;
          if (rise)
          begin
            // A master that declines the byte ends the read; wait for stop.
            if (sda_in)
              state <= RTCM_IDLE;
            else
              ack_drv <= 1'b1;
          end
          if (rd_load)
          begin
            ack_drv <= 1'b0;
            cnt     <= 3'd0;
            shift   <= rd_byte; // RULE8
            sda_oe  <= !rd_byte[7];
            state   <= RTCM_RD;
          end
        end
        default:
        begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Read value of a location; time comes from the holding buffer.
  function automatic logic [7:0] rd_val(input logic [4:0] a);
    if (a <= `RTCM_ADDR_WDAY)
      rd_val = shadow[a[2:0]]; // RULE9
    else if (a == `RTCM_ADDR_STATUS)
      rd_val = {sr_arst, sr_xtoscb, 1'b0, sr_clock_write_unlock, 1'b0, sr_alm, sr_bat, sr_total_power_loss_flag};
    else if (a > `RTCM_ADDR_LAST)
      rd_val = `RTCM_RESET_VALUE; // RULE4
    else
      rd_val = mem[a] & wmask(a); // RULE23
  endfunction

  // Holding buffer: refreshed at every read start so a tick cannot tear a read.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 7; i++)
        shadow[i] <= `RTCM_RESET_VALUE;
    end
    else if (rd_start)
    begin
      for (int i = 0; i < 7; i++)
        shadow[i] <= mem[i]; // RULE9
    end
  end

  // Next calendar values for one tick, all carries in BCD.
  always_comb
  begin
    logic c_min;
    logic c_hour;
    logic c_day;
    logic c_mon;
    logic c_year;
    logic leap;
    logic [7:0] hr;
    logic [7:0] hr_inc;
    logic [7:0] last_day;
    c_min  = 1'b0;
    c_hour = 1'b0;
    c_day  = 1'b0;
    c_mon  = 1'b0;
    c_year = 1'b0;
    last_day = 8'h31;
    hr     = mem[`RTCM_ADDR_HOUR];
    hr_inc = bcd_inc({2'b00, hr[5:0]});
    // BCD year divisible by 4: even tens with units 0,4,8 or odd tens with 2,6.
    leap   = (mem[`RTCM_ADDR_YEAR][1:0] == {mem[`RTCM_ADDR_YEAR][4], 1'b0}); // RULE17
    case (mem[`RTCM_ADDR_MONTH])
      8'h02:                      last_day = leap ? 8'h29 : 8'h28; // RULE18
      8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
      default:                    last_day = 8'h31;
    endcase
    nx_sec = bcd_inc(mem[`RTCM_ADDR_SEC]); // RULE21
    if (mem[`RTCM_ADDR_SEC] >= `RTCM_BCD_59)
    begin
      nx_sec = `RTCM_RESET_VALUE;
      c_min  = 1'b1;
    end
    nx_min = mem[`RTCM_ADDR_MIN];
    if (c_min)
    begin
      nx_min = bcd_inc(mem[`RTCM_ADDR_MIN]);
      if (mem[`RTCM_ADDR_MIN] >= `RTCM_BCD_59)
      begin
        nx_min = `RTCM_RESET_VALUE;
        c_hour = 1'b1;
      end
    end
    nx_hour = hr;
    if (c_hour && hr[`RTCM_HR_24H]) // RULE15
    begin
      nx_hour = {1'b1, 1'b0, hr_inc[5:0]};
      if ({2'b00, hr[5:0]} >= `RTCM_BCD_23)
      begin
        nx_hour = {1'b1, 7'h00};
        c_day   = 1'b1;
      end
    end
    else if (c_hour)
    begin
      if ({3'b000, hr[4:0]} == `RTCM_BCD_11)
      begin
        nx_hour = {2'b00, !hr[`RTCM_HR_PM], 5'h12}; // RULE22
        c_day   = hr[`RTCM_HR_PM];
      end
      else if ({3'b000, hr[4:0]} >= `RTCM_BCD_12)
        nx_hour = {2'b00, hr[`RTCM_HR_PM], 5'h01};
      else
        nx_hour = {2'b00, hr[`RTCM_HR_PM], hr_inc[4:0]};
    end
    nx_date = mem[`RTCM_ADDR_DATE];
    nx_wday = mem[`RTCM_ADDR_WDAY];
    if (c_day)
    begin
      nx_wday = (mem[`RTCM_ADDR_WDAY] >= `RTCM_WDAY_LAST) ? `RTCM_RESET_VALUE
                : mem[`RTCM_ADDR_WDAY] + 8'h01; // RULE14
      nx_date = bcd_inc(mem[`RTCM_ADDR_DATE]);
      if (mem[`RTCM_ADDR_DATE] >= last_day)
      begin
        nx_date = `RTCM_BCD_01;
        c_mon   = 1'b1;
      end
    end
    nx_month = mem[`RTCM_ADDR_MONTH];
    if (c_mon)
    begin
      nx_month = bcd_inc(mem[`RTCM_ADDR_MONTH]);
      if (mem[`RTCM_ADDR_MONTH] >= `RTCM_BCD_12)
      begin
        nx_month = `RTCM_BCD_01;
        c_year   = 1'b1;
      end
    end
    nx_year = mem[`RTCM_ADDR_YEAR];
    if (c_year)
      nx_year = (mem[`RTCM_ADDR_YEAR] >= `RTCM_BCD_99) ? `RTCM_RESET_VALUE
                : bcd_inc(mem[`RTCM_ADDR_YEAR]); // RULE13
  end

  // Location storage: a host write beats a tick on the same location.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < `RTCM_NUM_LOC; i++)
        mem[i] <= `RTCM_RESET_VALUE; // RULE12 RULE16
    end
    else
    begin
      if (tick)
      begin
        mem[`RTCM_ADDR_SEC]   <= nx_sec;
        mem[`RTCM_ADDR_MIN]   <= nx_min;
        mem[`RTCM_ADDR_HOUR]  <= nx_hour;
        mem[`RTCM_ADDR_DATE]  <= nx_date;
        mem[`RTCM_ADDR_MONTH] <= nx_month;
        mem[`RTCM_ADDR_YEAR]  <= nx_year;
        mem[`RTCM_ADDR_WDAY]  <= nx_wday;
      end
      if (time_wr || (wr_en && ptr > `RTCM_ADDR_WDAY)) // RULE11
        mem[ptr] <= in_byte & wmask(ptr); // RULE2
    end
  end

  // Status bits: alarm and battery flags can only be written to zero; the power-loss flag clears on a time write.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sr_arst   <= 1'b0;
      sr_xtoscb <= 1'b0;
      sr_clock_write_unlock   <= 1'b0;
      sr_alm    <= 1'b0;
      sr_bat    <= 1'b0;
      sr_total_power_loss_flag   <= 1'b1; // RULE12
      sr_read   <= 1'b0;
    end
    else
    begin
      if (wr_en && ptr == `RTCM_ADDR_STATUS)
      begin
        sr_arst   <= in_byte[`RTCM_SR_ARST];
        sr_xtoscb <= in_byte[`RTCM_SR_XTOSCB];
        sr_clock_write_unlock   <= in_byte[`RTCM_SR_CLOCK_WRITE_UNLOCK];
        sr_alm    <= sr_alm && in_byte[`RTCM_SR_ALM];
        sr_bat    <= sr_bat && in_byte[`RTCM_SR_BAT];
      end
      if (time_wr)
        sr_total_power_loss_flag <= 1'b0;
      if (rd_load && ptr == `RTCM_ADDR_STATUS)
        sr_read <= 1'b1;
      // Auto clear acts only once the read is closed by a stop.
      if (stop_c || start_c)
        sr_read <= 1'b0;
      if (stop_c && sr_read && sr_arst)
      begin
        sr_alm <= 1'b0;
        sr_bat <= 1'b0;
      end
    end
  end

  // Second divider: frozen until a time write, restarted at that write's stop.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      running      <= 1'b0;
      time_wr_pend <= 1'b0;
      tick_cnt     <= '0;
    end
    else
    begin
      if (time_wr)
        time_wr_pend <= 1'b1;
      if (start_c)
        time_wr_pend <= 1'b0;
      if (stop_c && (time_wr_pend || time_wr))
      begin
        running      <= 1'b1; // RULE19 RULE20
        time_wr_pend <= 1'b0;
        tick_cnt     <= '0;
      end
      else if (running)
        tick_cnt <= tick ? '0 : tick_cnt + TW'(1);
    end
  end

  assign tick = running && (tick_cnt == TW'(TICK_CYCLES - 1));

endmodule

// *** rtl/rtcm_pkg.sv ***
// Types shared by the clock/calendar core.
package rtcm_pkg;
  typedef enum logic [3:0] {
    RTCM_IDLE, RTCM_ADDR, RTCM_ADDR_ACK, RTCM_PTR, RTCM_PTR_ACK,
    RTCM_WR, RTCM_WR_ACK, RTCM_RD, RTCM_RD_ACK
  } rtcm_state_t;
  typedef logic [1:0] rtcm_sect_t;
endpackage

// *** rtl/rtcm_regs.svh ***
// Register offsets, field positions, masks and timing constants of the clock/calendar core.
`ifndef RTCM_REGS_SVH
`define RTCM_REGS_SVH

`define RTCM_SLAVE_ADDR       7'h6F
`define RTCM_ADDR_SEC         5'h00
`define RTCM_ADDR_MIN         5'h01
`define RTCM_ADDR_HOUR        5'h02
`define RTCM_ADDR_DATE        5'h03
`define RTCM_ADDR_MONTH       5'h04
`define RTCM_ADDR_YEAR        5'h05
`define RTCM_ADDR_WDAY        5'h06
`define RTCM_ADDR_STATUS      5'h07
`define RTCM_ADDR_IRQCTL      5'h08
`define RTCM_ADDR_UNUSED      5'h09
`define RTCM_ADDR_ATRIM       5'h0A
`define RTCM_ADDR_DTRIM       5'h0B
`define RTCM_ADDR_ALM_SEC     5'h0C
`define RTCM_ADDR_ALM_MIN     5'h0D
`define RTCM_ADDR_ALM_HOUR    5'h0E
`define RTCM_ADDR_ALM_DATE    5'h0F
`define RTCM_ADDR_ALM_MONTH   5'h10
`define RTCM_ADDR_ALM_WDAY    5'h11
`define RTCM_ADDR_LAST        5'h13
`define RTCM_NUM_LOC          20

`define RTCM_SR_ARST          7
`define RTCM_SR_XTOSCB        6
`define RTCM_SR_CLOCK_WRITE_UNLOCK          4
`define RTCM_SR_ALM           2
`define RTCM_SR_BAT           1
`define RTCM_SR_TOTAL_POWER_LOSS_FLAG          0
`define RTCM_HR_24H           7
`define RTCM_HR_PM            5

`define RTCM_MASK_SEC         8'h7F
`define RTCM_MASK_HOUR        8'hBF
`define RTCM_MASK_DATE        8'h3F
`define RTCM_MASK_MONTH       8'h1F
`define RTCM_MASK_WDAY        8'h07
`define RTCM_MASK_DTRIM       8'h07
`define RTCM_MASK_ALM_HOUR    8'hBF
`define RTCM_MASK_ALM_MONTH   8'h9F
`define RTCM_MASK_ALM_WDAY    8'h87
`define RTCM_MASK_ALL         8'hFF

`define RTCM_BCD_59           8'h59
`define RTCM_BCD_23           8'h23
`define RTCM_BCD_11           8'h11
`define RTCM_BCD_12           8'h12
`define RTCM_BCD_99           8'h99
`define RTCM_BCD_01           8'h01
`define RTCM_WDAY_LAST        8'h06

`define RTCM_CLK_PERIOD_NS    40
`define RTCM_TICK_PERIOD_NS   1000000000
`define RTCM_RESET_VALUE      8'h00

`endif
